// ### hw/fsrc_pkg.sv
// Shared constants and types for the flash suspend/resume controller
package fsrc_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int HALT_LATENCY_NS = 20000;
	// Longest time, so the count rounds down
	localparam int HALT_CYC_INT = HALT_LATENCY_NS / CLK_PERIOD_NS;
	localparam logic [11:0] HALT_CYC = 12'(HALT_CYC_INT);

	// ---------------------------------------------------------------
	// Field layout and reset values
	// ---------------------------------------------------------------
	localparam int OPC_W = 8;
	localparam int ADDR_W = 24;
	localparam int PAGE_LSB = 8;
	localparam int BLK64_LSB = 16;
	localparam logic [2:0] ADDR_BYTES = 3'h4;
	localparam logic FLAG_RST = 1'b0;
	localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;

	// ---------------------------------------------------------------
	// Opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_HALT_A = 8'h75, OP_HALT_B = 8'hb0, OP_RESUME_A = 8'h7a, OP_RESUME_B = 8'hd0;
	localparam logic [7:0] OP_RDSR1 = 8'h05, OP_RDSR2 = 8'h35, OP_RDSR3 = 8'h15, OP_RDSRI = 8'h65;
	localparam logic [7:0] OP_TERM = 8'hf0, OP_RSTEN = 8'h66, OP_RST = 8'h99, OP_WAKE = 8'hab;
	localparam logic [7:0] OP_ID_A = 8'h9f, OP_ID_B = 8'h90, OP_ID_C = 8'h94;
	localparam logic [7:0] OP_WREN = 8'h06, OP_WRDI = 8'h04, OP_VWREN = 8'h50, OP_BLKST_A = 8'h3c;
	localparam logic [7:0] OP_BLKST_B = 8'h3d, OP_RDOTP = 8'h4b, OP_RDDISC = 8'h5a, OP_WRAP = 8'h77;
	localparam logic [7:0] OP_RD_A = 8'h03, OP_RD_B = 8'h0b, OP_RD_C = 8'h3b, OP_RD_D = 8'h6b;
	localparam logic [7:0] OP_RD_E = 8'heb, OP_RD_F = 8'he7;
	localparam logic [7:0] OP_PG_A = 8'h02, OP_PG_B = 8'ha2, OP_PG_C = 8'h32, OP_SEQ_A = 8'had;
	localparam logic [7:0] OP_SEQ_B = 8'haf;
	localparam logic [7:0] OP_ER_A = 8'h20, OP_ER_B = 8'h52, OP_ER_C = 8'hd8, OP_CE_A = 8'h60;
	localparam logic [7:0] OP_CE_B = 8'hc7, OP_DPD = 8'hb9, OP_UDPD = 8'h79;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		CL_ANY = 3'b000, CL_PARKOK = 3'b001, CL_READ = 3'b010, CL_RESUME = 3'b011,
		CL_PGM = 3'b100, CL_HALT = 3'b101, CL_NEVER = 3'b110, CL_ERASE = 3'b111
	} fsrc_cls_t;
	typedef enum logic [1:0] {OK_PGM = 2'b00, OK_ERASE = 2'b01, OK_LOCKED = 2'b10} fsrc_op_kind_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_HALT = 2'b10} fsrc_state_t;
	typedef struct packed {
		logic [OPC_W-1:0] opcode;
		logic [ADDR_W-1:0] addr;
		logic [2:0] nbytes;
		logic aligned;
	} fsrc_frame_t;
	typedef struct packed {
		logic [OPC_W-1:0] opcode;
		logic [ADDR_W-1:0] addr;
		logic undef_data;
	} fsrc_cmd_t;

endpackage

// ### hw/fsrc_spi_rx.sv
// SPI opcode and address capture, brought into the ref_clk domain
`timescale 1ns/1ps
module fsrc_spi_rx (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Raw SPI pins
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	// Completed frame, pulse one cycle after chip select release is seen
	output logic frm_v_r,
	output fsrc_pkg::fsrc_frame_t frm_r
);
	logic [2:0] sclk_s;
	logic [2:0] cs_s;
	logic [1:0] si_s;
	logic [7:0] sh_r;
	logic [2:0] bit_cnt_r;
	logic [2:0] byte_cnt_r;
	logic [7:0] opc_r;
	logic [23:0] addr_r;
	logic sclk_rise;
	logic cs_rise;
	logic cs_fall;
	logic [7:0] byte_in;

	// Two-flop synchronisers; the third stage exists only for edge finding
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			sclk_s <= 3'h0;
			cs_s <= 3'h7;
			si_s <= 2'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], spi_sclk};
			cs_s <= {cs_s[1:0], spi_cs_n};
			si_s <= {si_s[0], spi_si};
		end
	end

	// Data is delayed as much as the clock, so sampling stays centred
	assign sclk_rise = sclk_s[1] & ~sclk_s[2] & ~cs_s[1];
	assign cs_rise = cs_s[1] & ~cs_s[2];
	assign cs_fall = ~cs_s[1] & cs_s[2];
	assign byte_in = {sh_r[6:0], si_s[1]};

	// MSB first; byte count saturates so long data phases are harmless
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			sh_r <= 8'h00;
			bit_cnt_r <= 3'h0;
			byte_cnt_r <= 3'h0;
			opc_r <= 8'h00;
			addr_r <= fsrc_pkg::ADDR_RST;
		end else if (cs_fall) begin
			bit_cnt_r <= 3'h0;
			byte_cnt_r <= 3'h0;
		end else if (sclk_rise) begin
			sh_r <= byte_in;
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (bit_cnt_r == 3'h7) begin
				if (byte_cnt_r != 3'h7) begin
					byte_cnt_r <= byte_cnt_r + 3'h1;
				end
				if (byte_cnt_r == 3'h0) begin
					opc_r <= byte_in;
				end else if (byte_cnt_r < fsrc_pkg::ADDR_BYTES) begin
					addr_r <= {addr_r[15:0], byte_in};
				end
			end
		end
	end

	// Report the frame when chip select goes back high
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			frm_v_r <= 1'b0;
			frm_r <= '0;
		end else begin
			frm_v_r <= cs_rise;
			if (cs_rise) begin
				frm_r <= '{opcode: opc_r, addr: addr_r, nbytes: byte_cnt_r, aligned: (bit_cnt_r == 3'h0)};
			end
		end
	end

endmodule

// ### hw/fsrc_gate.sv
// Command admission table for busy and parked operation states
`timescale 1ns/1ps
module fsrc_gate (
	// Opcode under test
	input wire logic [7:0] opcode,
	// Current device state
	input wire logic occupied,
	input wire logic pgm_parked,
	input wire logic ers_parked,
	// Verdict
	output fsrc_pkg::fsrc_cls_t cls,
	output logic allowed
);

	// Group opcodes by the states in which they may run
	function automatic fsrc_pkg::fsrc_cls_t classify(input logic [7:0] op);
		case (op)
			fsrc_pkg::OP_RDSR1, fsrc_pkg::OP_RDSR2, fsrc_pkg::OP_RDSR3, fsrc_pkg::OP_RDSRI,
			fsrc_pkg::OP_TERM, fsrc_pkg::OP_RSTEN, fsrc_pkg::OP_RST, fsrc_pkg::OP_WAKE,
			fsrc_pkg::OP_ID_A, fsrc_pkg::OP_ID_B, fsrc_pkg::OP_ID_C: classify = fsrc_pkg::CL_ANY;
			fsrc_pkg::OP_WREN, fsrc_pkg::OP_WRDI, fsrc_pkg::OP_VWREN, fsrc_pkg::OP_BLKST_A,
			fsrc_pkg::OP_BLKST_B, fsrc_pkg::OP_RDOTP, fsrc_pkg::OP_RDDISC,
			fsrc_pkg::OP_WRAP: classify = fsrc_pkg::CL_PARKOK;
			fsrc_pkg::OP_RD_A, fsrc_pkg::OP_RD_B, fsrc_pkg::OP_RD_C, fsrc_pkg::OP_RD_D,
			fsrc_pkg::OP_RD_E, fsrc_pkg::OP_RD_F: classify = fsrc_pkg::CL_READ;
			fsrc_pkg::OP_RESUME_A, fsrc_pkg::OP_RESUME_B: classify = fsrc_pkg::CL_RESUME;
			fsrc_pkg::OP_HALT_A, fsrc_pkg::OP_HALT_B: classify = fsrc_pkg::CL_HALT;
			fsrc_pkg::OP_PG_A, fsrc_pkg::OP_PG_B, fsrc_pkg::OP_PG_C, fsrc_pkg::OP_SEQ_A,
			fsrc_pkg::OP_SEQ_B: classify = fsrc_pkg::CL_PGM;
			fsrc_pkg::OP_ER_A, fsrc_pkg::OP_ER_B, fsrc_pkg::OP_ER_C, fsrc_pkg::OP_CE_A,
			fsrc_pkg::OP_CE_B: classify = fsrc_pkg::CL_ERASE;
			default: classify = fsrc_pkg::CL_NEVER;
		endcase
	endfunction

	assign cls = classify(opcode);

	// Program-parked takes precedence over erase-parked when both hold
	always_comb begin
		if (occupied) begin
			allowed = (cls == fsrc_pkg::CL_ANY) || (cls == fsrc_pkg::CL_HALT);
		end else if (pgm_parked) begin
			allowed = cls inside {fsrc_pkg::CL_ANY, fsrc_pkg::CL_PARKOK, fsrc_pkg::CL_READ,
				fsrc_pkg::CL_RESUME};
		end else if (ers_parked) begin
			allowed = cls inside {fsrc_pkg::CL_ANY, fsrc_pkg::CL_PARKOK, fsrc_pkg::CL_READ,
				fsrc_pkg::CL_RESUME, fsrc_pkg::CL_PGM};
		end else begin
			allowed = !(cls inside {fsrc_pkg::CL_HALT, fsrc_pkg::CL_RESUME});
		end
	end

endmodule

// ### hw/fsrc_top.sv
// Suspend/resume sequencer and command admission for the flash core
`timescale 1ns/1ps

module fsrc_top (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// SPI pins, asynchronous to ref_clk
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	// Array engine reports, same clock
	input wire logic op_begin,
	input wire fsrc_pkg::fsrc_op_kind_t op_kind,
	input wire logic [fsrc_pkg::ADDR_W-1:0] op_addr,
	input wire logic op_end,
	input wire logic eng_stopped,
	// Array engine control
	output logic eng_halt_r,
	output logic eng_resume_r,
	output logic eng_resume_pgm_r,
	// Commands passed on to the rest of the device
	output logic cmd_valid_r,
	output fsrc_pkg::fsrc_cmd_t cmd_r,
	output logic cmd_drop_r,
	// Status flags
	output logic device_occupied_flag_r,
	output logic halted_op_flag_r,
	output logic program_halted_flag_r,
	output logic erase_halted_flag_r
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic frm_v;
	fsrc_pkg::fsrc_frame_t frm;
	fsrc_pkg::fsrc_cls_t cls;
	logic allowed;
	fsrc_pkg::fsrc_state_t st_r;
	fsrc_pkg::fsrc_state_t st_nxt;
	fsrc_pkg::fsrc_op_kind_t cur_kind_r;
	logic [fsrc_pkg::ADDR_W-1:0] cur_addr_r;
	logic [fsrc_pkg::ADDR_W-1:0] pgm_addr_r;
	logic [fsrc_pkg::ADDR_W-1:0] ers_addr_r;
	logic [11:0] halt_cnt_r;
	logic frame_ok;
	logic halt_go;
	logic resume_go;
	logic pgm_blocked;
	logic fwd;
	logic halt_done;
	logic pgm_nxt;
	logic ers_nxt;
	logic rd_undef;

	// Compare two addresses above a given bit, used for page and block hits
	function automatic logic same_area(input logic [23:0] a, input logic [23:0] b, input int lsb);
		same_area = ((a ^ b) >> lsb) == 24'h000000;
	endfunction

	// ---------------------------------------------------------------
	// Frame capture and admission table
	// ---------------------------------------------------------------
	fsrc_spi_rx u_rx (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_si(spi_si),
		.frm_v_r(frm_v),
		.frm_r(frm)
	);

	fsrc_gate u_gate (
		.opcode(frm.opcode),
		.occupied(device_occupied_flag_r),
		.pgm_parked(program_halted_flag_r),
		.ers_parked(erase_halted_flag_r),
		.cls(cls),
		.allowed(allowed)
	);

	// ---------------------------------------------------------------
	// Command decision
	// ---------------------------------------------------------------
	// A frame counts only if the opcode byte is whole and the frame ends on a byte
	assign frame_ok = frm_v && frm.aligned && (frm.nbytes != 3'h0);

	// Halt is taken only from a haltable running operation; the write
	// permit latch plays no part, so no enable is needed beforehand
	assign halt_go = frame_ok && (cls == fsrc_pkg::CL_HALT) && allowed
		&& (st_r == fsrc_pkg::ST_RUN) && (cur_kind_r != fsrc_pkg::OK_LOCKED);

	// Gate admits resume only when parked and not occupied
	assign resume_go = frame_ok && (cls == fsrc_pkg::CL_RESUME) && allowed;

	// During an erase halt a program needs a full address outside the halted block
	assign pgm_blocked = (cls == fsrc_pkg::CL_PGM) && erase_halted_flag_r && !program_halted_flag_r
		&& ((frm.nbytes < fsrc_pkg::ADDR_BYTES)
		|| same_area(frm.addr, ers_addr_r, fsrc_pkg::BLK64_LSB));

	// Everything else that the table admits is handed on
	assign fwd = frame_ok && allowed && !pgm_blocked
		&& (cls != fsrc_pkg::CL_HALT) && (cls != fsrc_pkg::CL_RESUME);

	// Reads that land on a parked page or block are flagged for garbage data
	assign rd_undef = (cls == fsrc_pkg::CL_READ)
		&& ((program_halted_flag_r && same_area(frm.addr, pgm_addr_r, fsrc_pkg::PAGE_LSB))
		|| (erase_halted_flag_r && same_area(frm.addr, ers_addr_r, fsrc_pkg::BLK64_LSB)));

	// ---------------------------------------------------------------
	// Operation sequencer
	// ---------------------------------------------------------------
	// A finish that races the halt wins: the operation simply ends
	always_comb begin
		st_nxt = st_r;
		halt_done = 1'b0;
		unique case (st_r)
			fsrc_pkg::ST_IDLE: begin
				if (resume_go || op_begin) begin
					st_nxt = fsrc_pkg::ST_RUN;
				end
			end
			fsrc_pkg::ST_RUN: begin
				if (op_end) begin
					st_nxt = fsrc_pkg::ST_IDLE;
				end else if (halt_go) begin
					st_nxt = fsrc_pkg::ST_HALT;
				end
			end
			fsrc_pkg::ST_HALT: begin
				if (op_end) begin
					st_nxt = fsrc_pkg::ST_IDLE;
				end else if (eng_stopped || (halt_cnt_r == fsrc_pkg::HALT_CYC - 12'h001)) begin
					st_nxt = fsrc_pkg::ST_IDLE;
					halt_done = 1'b1;
				end
			end
			default: begin
				st_nxt = fsrc_pkg::ST_IDLE;
			end
		endcase
	end

	// State register and the occupied flag that follows it
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			st_r <= fsrc_pkg::ST_IDLE;
			device_occupied_flag_r <= fsrc_pkg::FLAG_RST;
		end else begin
			st_r <= st_nxt;
			device_occupied_flag_r <= (st_nxt != fsrc_pkg::ST_IDLE);
		end
	end

	// Halt latency counter; the forced halt bounds the wait even if the engine is slow
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			halt_cnt_r <= 12'h000;
		end else if (st_r == fsrc_pkg::ST_HALT) begin
			halt_cnt_r <= halt_cnt_r + 12'h001;
		end else begin
			halt_cnt_r <= 12'h000;
		end
	end

	// Engine freeze request follows the halting state
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			eng_halt_r <= 1'b0;
		end else begin
			eng_halt_r <= (st_nxt == fsrc_pkg::ST_HALT);
		end
	end

	// ---------------------------------------------------------------
	// Halted flags
	// ---------------------------------------------------------------
	// Program and erase each keep their own flag so both may stand at once
	always_comb begin
		pgm_nxt = program_halted_flag_r;
		ers_nxt = erase_halted_flag_r;
		if (halt_done) begin
			if (cur_kind_r == fsrc_pkg::OK_PGM) begin
				pgm_nxt = 1'b1;
			end else begin
				ers_nxt = 1'b1;
			end
		end
		if (resume_go) begin
			if (program_halted_flag_r) begin
				pgm_nxt = 1'b0;
			end else begin
				ers_nxt = 1'b0;
			end
		end
	end

	// General flag is the OR, so it only drops once both are clear
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			program_halted_flag_r <= fsrc_pkg::FLAG_RST;
			erase_halted_flag_r <= fsrc_pkg::FLAG_RST;
			halted_op_flag_r <= fsrc_pkg::FLAG_RST;
		end else begin
			program_halted_flag_r <= pgm_nxt;
			erase_halted_flag_r <= ers_nxt;
			halted_op_flag_r <= pgm_nxt | ers_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Operation context
	// ---------------------------------------------------------------
	// Parked contexts are kept so the engine continues rather than restarts
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cur_kind_r <= fsrc_pkg::OK_PGM;
			cur_addr_r <= fsrc_pkg::ADDR_RST;
			pgm_addr_r <= fsrc_pkg::ADDR_RST;
			ers_addr_r <= fsrc_pkg::ADDR_RST;
		end else begin
			if ((st_r == fsrc_pkg::ST_IDLE) && op_begin && !resume_go) begin
				cur_kind_r <= op_kind;
				cur_addr_r <= op_addr;
			end
			if (halt_done && (cur_kind_r == fsrc_pkg::OK_PGM)) begin
				pgm_addr_r <= cur_addr_r;
			end
			if (halt_done && (cur_kind_r != fsrc_pkg::OK_PGM)) begin
				ers_addr_r <= cur_addr_r;
			end
			if (resume_go) begin
				cur_kind_r <= program_halted_flag_r ? fsrc_pkg::OK_PGM : fsrc_pkg::OK_ERASE;
				cur_addr_r <= program_halted_flag_r ? pgm_addr_r : ers_addr_r;
			end
		end
	end

	// Resume pulse tells the engine which parked context to pick up
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			eng_resume_r <= 1'b0;
			eng_resume_pgm_r <= 1'b0;
		end else begin
			eng_resume_r <= resume_go;
			if (resume_go) begin
				eng_resume_pgm_r <= program_halted_flag_r;
			end
		end
	end

	// ---------------------------------------------------------------
	// Command hand-off
	// ---------------------------------------------------------------
	// Dropped frames never reach the rest of the device, so latch and state stay put
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cmd_valid_r <= 1'b0;
			cmd_drop_r <= 1'b0;
			cmd_r <= '0;
		end else begin
			cmd_valid_r <= fwd;
			cmd_drop_r <= frm_v && !(fwd || halt_go || resume_go);
			if (fwd) begin
				cmd_r <= '{opcode: frm.opcode, addr: frm.addr, undef_data: rd_undef};
			end
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	// Cycles the freeze request has stood; kept apart from the design's own counter
	// so that a broken forced halt is caught rather than mirrored
	logic [11:0] halt_wait_r;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			halt_wait_r <= 12'h000;
		end else if (eng_halt_r) begin
			halt_wait_r <= halt_wait_r + 12'h001;
		end else begin
			halt_wait_r <= 12'h000;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	halt_latency_a: assert property (
		eng_halt_r |-> halt_wait_r < fsrc_pkg::HALT_CYC)
		else $error("operation not halted within latency");

	halt_flags_a: assert property (
		$rose(erase_halted_flag_r) || $rose(program_halted_flag_r) |-> halted_op_flag_r)
		else $error("general halted flag missing");

	halt_free_a: assert property (
		$rose(halted_op_flag_r) |-> !device_occupied_flag_r && $past(eng_halt_r))
		else $error("halt left device occupied");

	locked_op_a: assert property (
		frm_v && (cls == fsrc_pkg::CL_HALT) && (cur_kind_r == fsrc_pkg::OK_LOCKED)
		|=> !eng_halt_r)
		else $error("unhaltable operation was halted");

	no_erase_a: assert property (
		frm_v && (cls == fsrc_pkg::CL_ERASE) && program_halted_flag_r |=> cmd_drop_r && !cmd_valid_r)
		else $error("erase passed during program halt");

	pgm_block_a: assert property (
		frm_v && (cls == fsrc_pkg::CL_PGM) && erase_halted_flag_r && !program_halted_flag_r
		&& same_area(frm.addr, ers_addr_r, fsrc_pkg::BLK64_LSB) |=> !cmd_valid_r)
		else $error("program into halted erase block");

	short_frame_a: assert property (
		frm_v && !frm.aligned |=> cmd_drop_r && !cmd_valid_r && !eng_resume_r)
		else $error("misaligned frame acted upon");

	resume_busy_a: assert property (
		frm_v && (cls == fsrc_pkg::CL_RESUME) && device_occupied_flag_r |=> !eng_resume_r)
		else $error("resume taken while occupied");

	power_down_a: assert property (
		frm_v && (frm.opcode == fsrc_pkg::OP_DPD) && (device_occupied_flag_r || halted_op_flag_r)
		|=> cmd_drop_r)
		else $error("power-down passed while active");

	resume_flags_a: assert property (
		eng_resume_r |-> device_occupied_flag_r
		&& ($fell(program_halted_flag_r) || $fell(erase_halted_flag_r)))
		else $error("resume flags not updated");

	nested_order_a: assert property (
		eng_resume_r && erase_halted_flag_r |-> eng_resume_pgm_r ##1 device_occupied_flag_r)
		else $error("nested resume picked erase first");

endmodule

// ### dv/fsrc_host.sv
// SPI host model issuing opcode frames to the controller
`timescale 1ns/1ps
module fsrc_host (
	// SPI pins
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_si
);
	// ---------------------------------------------------------------
	// Idle pins
	// ---------------------------------------------------------------
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
	end
	// One framed transfer, MSB first, left-justified word
	task automatic send(input logic [31:0] word, input int nbits);
		// Gap goes first, so the caller is back in time to see the one-cycle answer
		#100;
		spi_cs_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			spi_si = word[31-i];
			#62.5 spi_sclk = 1'b1;
			#62.5 spi_sclk = 1'b0;
		end
		#62.5 spi_cs_n = 1'b1;
		// Flip the released line so a stale bit never looks valid
		spi_si = ~spi_si;
	endtask
endmodule

// ### dv/tb.sv
// Self-checking bench for the flash suspend/resume controller
`timescale 1ns/1ps
module tb;
	logic ref_clk = 1'b0;
	logic nrst, spi_sclk, spi_cs_n, spi_si, op_begin, op_end, eng_stopped;
	fsrc_pkg::fsrc_op_kind_t op_kind;
	logic [23:0] op_addr, pa, ea;
	logic eng_halt_r, eng_resume_r, eng_resume_pgm_r, cmd_valid_r, cmd_drop_r, occ, halted_op_flag, ph, eh;
	fsrc_pkg::fsrc_cmd_t cmd_r;
	int n_fail = 0;
	int n_checks = 0;
	int m_kind, n;
	logic m_occ = 1'b0;
	logic m_ph = 1'b0;
	logic m_eh = 1'b0;
	logic [31:0] rs = 32'h20a4;
	logic [7:0] tbl [22] = '{8'h05, 8'h65, 8'hf0, 8'h66, 8'h99, 8'h9f, 8'hab, 8'h03, 8'h3c, 8'h4b, 8'h5a,
		8'h77, 8'h06, 8'h20, 8'h60, 8'h02, 8'had, 8'hb9, 8'h79, 8'h9b, 8'h36, 8'h01};

	// ---------------------------------------------------------------
	// Clock, host and design
	// ---------------------------------------------------------------
	always #5 ref_clk = ~ref_clk;
	fsrc_host host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si));
	fsrc_top dut (.ref_clk(ref_clk), .nrst(nrst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
		.op_begin(op_begin), .op_kind(op_kind), .op_addr(op_addr), .op_end(op_end), .eng_stopped(eng_stopped),
		.eng_halt_r(eng_halt_r), .eng_resume_r(eng_resume_r), .eng_resume_pgm_r(eng_resume_pgm_r),
		.cmd_valid_r(cmd_valid_r), .cmd_r(cmd_r), .cmd_drop_r(cmd_drop_r), .device_occupied_flag_r(occ),
		.halted_op_flag_r(halted_op_flag), .program_halted_flag_r(ph), .erase_halted_flag_r(eh));

	// Xorshift source for target addresses
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction

	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Reference model: 1 handed on, 2 dropped, 3 halt, 4 resume
	// ---------------------------------------------------------------
	function automatic int exp_out(logic [7:0] op, int nb, logic [23:0] a);
		logic pk, alw, pg;
		pk = op inside {8'h03, 8'h3c, 8'h4b, 8'h5a, 8'h77, 8'h06};
		alw = op inside {8'h05, 8'h65, 8'hf0, 8'h66, 8'h99, 8'h9f, 8'hab};
		pg = op inside {8'h02, 8'had};
		if (nb % 8 != 0) return 2;
		if (op inside {8'h75, 8'hb0}) return (m_occ && m_kind != 2) ? 3 : 2;
		if (op inside {8'h7a, 8'hd0}) return (!m_occ && (m_ph || m_eh)) ? 4 : 2;
		if (m_occ) return alw ? 1 : 2;
		if (m_ph) return (alw || pk) ? 1 : 2;
		if (m_eh) return (alw || pk || (pg && a[23:16] != ea[23:16])) ? 1 : 2;
		return 1;
	endfunction

	task automatic flags();
		check("occupied", occ, m_occ);
		check("prog halted", ph, m_ph);
		check("erase halted", eh, m_eh);
		check("halted", halted_op_flag, m_ph | m_eh);
	endtask

	// Send one frame and compare what comes out with the model
	task automatic frame(logic [7:0] op, int nb, logic [23:0] a);
		int got, ex;
		logic und;
		got = 0;
		ex = exp_out(op, nb, a);
		host.send({op, a}, nb);
		for (int i = 0; i < 12 && got == 0; i++) begin
			@(negedge ref_clk);
			if (cmd_valid_r === 1'b1) got = 1;
			if (cmd_drop_r === 1'b1) got = 2;
			if (eng_halt_r === 1'b1) got = 3;
			if (eng_resume_r === 1'b1) got = 4;
		end
		check("outcome", got, ex);
		if (got == 1 && nb == 32) check("handed on", cmd_r[32:1], {op, a});
		// A read into a parked page or block is passed on, marked as garbage
		und = (m_ph && a[23:8] == pa[23:8]) || (m_eh && a[23:16] == ea[23:16]);
		if (got == 1 && op == 8'h03) check("undef", cmd_r.undef_data, und);
		if (got == 4) begin
			check("resume ctx", eng_resume_pgm_r, m_ph);
			m_kind = m_ph ? 0 : 1;
			if (m_ph) m_ph = 1'b0;
			else m_eh = 1'b0;
			m_occ = 1'b1;
		end
		if (got == 4 || ex == 3) flags();
	endtask

	// Engine event: 0 begin, 1 end, 2 stopped
	task automatic eng(int w, int k, logic [23:0] a);
		@(negedge ref_clk);
		op_begin = (w == 0);
		op_end = (w == 1);
		eng_stopped = (w == 2);
		op_kind = fsrc_pkg::fsrc_op_kind_t'(k);
		op_addr = a;
		@(negedge ref_clk);
		{op_begin, op_end, eng_stopped} = 3'h0;
		m_occ = (w == 0);
		if (w == 0) m_kind = k;
		if (w == 2 && m_kind == 0) m_ph = 1'b1;
		if (w == 2 && m_kind != 0) m_eh = 1'b1;
		@(negedge ref_clk);
		flags();
	endtask

	// Every listed opcode in the present state
	task automatic sweep(string nm);
		for (int i = 0; i < 22; i++) frame(tbl[i], 32, i % 2 ? (m_ph ? pa : ea) : 24'(rnd()));
		$display("test %s done", nm);
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{nrst, op_begin, op_end, eng_stopped} = 4'h0;
		op_kind = fsrc_pkg::OK_PGM;
		op_addr = 24'h000000;
		repeat (4) @(negedge ref_clk);
		nrst = 1'b1;
		repeat (4) @(negedge ref_clk);
		flags();
		pa = 24'(rnd());
		ea = 24'(rnd());
		frame(8'h75, 8, 24'h0);
		frame(8'h7a, 8, 24'h0);
		eng(0, 0, pa);
		sweep("busy");
		frame(8'hd0, 8, 24'h0);
		frame(8'h75, 12, 24'h0);
		frame(8'h75, 8, 24'h0);
		eng(2, 0, pa);
		sweep("program parked");
		frame(8'h7a, 8, 24'h0);
		eng(1, 0, pa);
		eng(0, 2, pa);
		frame(8'hb0, 8, 24'h0);
		eng(1, 2, pa);
		$display("test program halt done");
		eng(0, 1, ea);
		frame(8'hb0, 8, 24'h0);
		eng(2, 1, ea);
		sweep("erase parked");
		pa = ea ^ 24'h010000;
		eng(0, 0, pa);
		frame(8'h75, 8, 24'h0);
		eng(2, 0, pa);
		frame(8'hd0, 8, 24'h0);
		eng(1, 0, pa);
		frame(8'hd0, 8, 24'h0);
		$display("test nested halt done");
		frame(8'hb0, 8, 24'h0);
		n = 0;
		while (eh !== 1'b1 && n < 2100) begin
			@(negedge ref_clk);
			n++;
		end
		check("halt latency", n <= fsrc_pkg::HALT_CYC_INT + 1, 1);
		m_occ = 1'b0;
		m_eh = 1'b1;
		flags();
		$display("test latency done");
		wrap_up();
	end

	// Watchdog well past the expected run length
	initial begin
		#1000000;
		n_fail++;
		wrap_up();
	end
endmodule
